// *** verilog/acrc_pkg.sv ***
// shared constants, carriers and helpers of the converter control block
package acrc_pkg;
    // data path shape
    localparam int RES_W   = 12;
    localparam int N_IN    = 13;
    localparam int ADDR_W  = 8;
    localparam int BIT_DIV = 4;     // clock cycles per sample or bit step

    // register byte offsets
    localparam logic [7:0] OFF_CTL0  = 8'h00;
    localparam logic [7:0] OFF_CTL1  = 8'h04;
    localparam logic [7:0] OFF_RESH  = 8'h08;
    localparam logic [7:0] OFF_RESL  = 8'h0C;
    localparam logic [7:0] OFF_ISTAT = 8'h10;
    localparam logic [7:0] OFF_IMASK = 8'h14;

    // field positions
    localparam int CTL0_ON_BIT   = 0;
    localparam int CTL0_GO_BIT   = 1;
    localparam int CTL0_CHS_LSB  = 2;
    localparam int CTL1_PCFG_LSB = 0;
    localparam int CTL1_PREF_BIT = 4;
    localparam int CTL1_NREF_BIT = 5;
    localparam int IRQ_DONE_BIT  = 0;
    localparam int GAP_LO_IDX    = 5;
    localparam int GAP_HI_IDX    = 7;

    // reset values and codes
    localparam logic [3:0] CHS_RST         = 4'h0;
    localparam logic [3:0] CHS_LAST        = 4'hC;
    localparam logic [3:0] CHS_GAP_LO      = 4'h5;
    localparam logic [3:0] CHS_GAP_HI      = 4'h7;
    localparam logic [3:0] PCFG_ALL_ANALOG = 4'h0;
    localparam logic [3:0] PCFG_PB_DIGITAL = 4'h7;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    typedef struct packed {
        logic [3:0] chan;
        logic       on;
    } acrc_ctl0_type;

    typedef struct packed {
        logic       nref;
        logic       pref;
        logic [3:0] pcfg;
    } acrc_ctl1_type;

    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_CONV}
        acrc_sar_state_type;

    // number of analog inputs, counted from input 0 upward
    function automatic logic [3:0] acrc_analog_count(input logic [3:0] code);
        case (code)
            4'h0, 4'h1, 4'h2: acrc_analog_count = 4'hD;
            4'h3:             acrc_analog_count = 4'hC;
            4'h4:             acrc_analog_count = 4'hB;
            4'h5:             acrc_analog_count = 4'hA;
            4'h6:             acrc_analog_count = 4'h9;
            4'h7:             acrc_analog_count = 4'h8;
            4'h8, 4'h9:       acrc_analog_count = 4'h7;
            4'hA:             acrc_analog_count = 4'h6;
            4'hB:             acrc_analog_count = 4'h5;
            4'hC:             acrc_analog_count = 4'h3;
            4'hD:             acrc_analog_count = 4'h2;
            4'hE:             acrc_analog_count = 4'h1;
            default:          acrc_analog_count = 4'h0;
        endcase
    endfunction
endpackage

// *** verilog/acrc_sar.sv ***
// successive approximation sequencer with its own bit-rate divider
`timescale 1ns/1ps
module acrc_sar
    import acrc_pkg::*;
#(
    parameter int WIDTH = RES_W,
    parameter int DIV   = BIT_DIV
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             comp,
    output logic                  busy,
    output logic                  done,
    output logic                  sampling,
    output logic [WIDTH-1:0]      trial,
    output logic [WIDTH-1:0]      result
);
    acrc_sar_state_type state_q;
    logic [7:0]         cnt_q;
    logic [WIDTH-1:0]   mask_q;
    logic [WIDTH-1:0]   trial_q;
    logic [WIDTH-1:0]   result_q;
    logic               done_q;
    wire                tick = (cnt_q == 8'(DIV - 1));
    // keep the trial bit when the input is above the trial level; the
    // comparator answer lags the trial by two sync flops, so DIV >= 3
    wire  [WIDTH-1:0]   kept = comp ? trial_q : (trial_q & ~mask_q);

    assign busy     = (state_q != SAR_IDLE);
    assign sampling = (state_q == SAR_SAMPLE);
    assign done     = done_q;
    assign trial    = trial_q;
    assign result   = result_q;

    // divider restarts on every start so each step lasts DIV cycles
    always_ff @(posedge aclk) begin
        if (!aresetn || start || tick) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // sample one step, then one step per result bit, msb first
    always_ff @(posedge aclk) begin
        done_q <= 1'b0;
        if (!aresetn) begin
            state_q  <= SAR_IDLE;
            mask_q   <= '0;
            trial_q  <= '0;
            result_q <= '0;
        end else if (abort) begin
            state_q <= SAR_IDLE;            // result left untouched
        end else begin
            case (state_q)
                SAR_IDLE: begin
                    if (start) begin
                        state_q <= SAR_SAMPLE;
                    end
                end
                SAR_SAMPLE: begin
                    if (tick) begin
                        state_q <= SAR_CONV;
                        mask_q  <= {1'b1, {(WIDTH-1){1'b0}}};
                        trial_q <= {1'b1, {(WIDTH-1){1'b0}}};
                    end
                end
                SAR_CONV: begin
                    if (tick) begin
                        mask_q  <= mask_q >> 1;
                        trial_q <= kept | (mask_q >> 1);
                        if (mask_q[0]) begin
                            state_q  <= SAR_IDLE;
                            result_q <= kept;
                            done_q   <= 1'b1;
                        end
                    end
                end
                default: state_q <= SAR_IDLE;
            endcase
        end
    end
endmodule // acrc_sar

// *** verilog/acrc_top.sv ***
// converter control registers, axi4-lite slave and pin-side selects
`timescale 1ns/1ps
module acrc_top
    import acrc_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1,
    parameter int DIV       = BIT_DIV
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              portb_analog_default,
    input  wire logic              comparator_in,
    output logic                   irq,
    output logic                   converter_on,
    output logic [3:0]             analog_channel_select,
    output logic                   channel_valid,
    output logic                   negative_reference_select,
    output logic                   positive_reference_select,
    output logic [N_IN-1:0]        analog_pin_mask,
    output logic                   sample_hold,
    output logic [RES_W-1:0]       dac_code
);
    acrc_ctl0_type    ctl0_q;
    acrc_ctl1_type    ctl1_q;
    logic [RES_W-1:0] result_q;
    logic             done_flag_q;
    logic             done_mask_q;
    logic             irq_q;
    logic             chan_valid_q;
    logic             sample_q;
    logic [N_IN-1:0]  amask_q;
    logic [N_IN-1:0]  amask_d;
    logic             comp_s1_q;
    logic             comp_s2_q;
    logic             strap_s1_q;
    logic             strap_s2_q;
    logic             aw_got_q;
    logic             w_got_q;
    logic             awready_q;
    logic             wready_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic [7:0]       awaddr_q;
    logic [7:0]       wdata_q;
    logic             wstrb0_q;
    logic             arready_q;
    logic             rvalid_q;
    logic [31:0]      rdata_q;
    logic [1:0]       rresp_q;
    logic [7:0]       rd_addr_q;
    logic             sar_busy;
    logic             sar_done;
    logic             sar_sampling;
    logic [RES_W-1:0] sar_trial;
    logic [RES_W-1:0] sar_result;

    // pins from outside the clock domain pass two flops first
    always_ff @(posedge aclk) begin
        comp_s1_q  <= comparator_in;
        comp_s2_q  <= comp_s1_q;
        strap_s1_q <= portb_analog_default;
        strap_s2_q <= strap_s1_q;
    end

    // write path decode, only byte lane 0 carries register bits
    wire wr_fire  = aw_got_q & w_got_q & ~bvalid_q;
    wire wr_en    = wr_fire & wstrb0_q;
    wire wr_ctl0  = wr_en & (awaddr_q == OFF_CTL0);
    wire wr_ctl1  = wr_en & (awaddr_q == OFF_CTL1);
    wire wr_istat = wr_en & (awaddr_q == OFF_ISTAT);
    wire wr_imask = wr_en & (awaddr_q == OFF_IMASK);
    wire wr_hit   = (awaddr_q == OFF_CTL0) | (awaddr_q == OFF_CTL1) |
                    (awaddr_q == OFF_RESH) | (awaddr_q == OFF_RESL) |
                    (awaddr_q == OFF_ISTAT) | (awaddr_q == OFF_IMASK);
    wire new_go   = wdata_q[CTL0_GO_BIT];
    wire new_on   = wdata_q[CTL0_ON_BIT];

    // start needs the converter already on; go with on in one write from off
    // does not start, so software waits out the hold time after enabling
    wire start_p  = wr_ctl0 & new_go & new_on & ctl0_q.on & ~sar_busy;
    wire abort_p  = wr_ctl0 & sar_busy & (~new_go | ~new_on);
    wire clr_done = wr_istat & wdata_q[IRQ_DONE_BIT];

    // channel routing: codes above 12 and the small-package gap float
    wire chs_gap    = (ctl0_q.chan >= CHS_GAP_LO) &
                      (ctl0_q.chan <= CHS_GAP_HI);
    wire chan_ok    = (ctl0_q.chan <= CHS_LAST) &
                      (LARGE_PKG | ~chs_gap);
    wire [3:0] acnt = acrc_analog_count(ctl1_q.pcfg);

    // read path decode, the unused upper bits read as zero
    wire [7:0] rd_ctl0  = {2'h0, ctl0_q.chan, sar_busy, ctl0_q.on};
    wire [7:0] rd_ctl1  = {2'h0, ctl1_q};
    wire [7:0] rd_resh  = {4'h0, result_q[RES_W-1:8]};
    wire [7:0] rd_resl  = result_q[7:0];
    wire [7:0] rd_istat = {7'h00, done_flag_q};
    wire [7:0] rd_imask = {7'h00, done_mask_q};
    wire       rd_hit   = (s_axi_araddr == OFF_CTL0) |
                          (s_axi_araddr == OFF_CTL1) |
                          (s_axi_araddr == OFF_RESH) |
                          (s_axi_araddr == OFF_RESL) |
                          (s_axi_araddr == OFF_ISTAT) |
                          (s_axi_araddr == OFF_IMASK);
    wire [7:0] rd_byte  =
        (s_axi_araddr == OFF_CTL0)  ? rd_ctl0  :
        (s_axi_araddr == OFF_CTL1)  ? rd_ctl1  :
        (s_axi_araddr == OFF_RESH)  ? rd_resh  :
        (s_axi_araddr == OFF_RESL)  ? rd_resl  :
        (s_axi_araddr == OFF_ISTAT) ? rd_istat :
        (s_axi_araddr == OFF_IMASK) ? rd_imask : 8'h00;

    // per-input analog decode; small package has no inputs 5 to 7
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_amask
            localparam logic [3:0] IDX = 4'(gi);
            localparam bit MISSING = (gi >= GAP_LO_IDX) &&
                                     (gi <= GAP_HI_IDX);
            assign amask_d[gi] = (IDX < acnt) &&
                                 (LARGE_PKG || !MISSING);
        end
    endgenerate

    // address and data are taken separately, either may come first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q  <= 1'b0;
            awready_q <= 1'b1;
            awaddr_q  <= 8'h00;
        end else if (s_axi_awvalid && awready_q) begin
            aw_got_q  <= 1'b1;
            awready_q <= 1'b0;
            awaddr_q  <= 8'(s_axi_awaddr);
        end else if (bvalid_q && s_axi_bready) begin
            aw_got_q  <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_q  <= 1'b0;
            wready_q <= 1'b1;
            wdata_q  <= 8'h00;
            wstrb0_q <= 1'b0;
        end else if (s_axi_wvalid && wready_q) begin
            w_got_q  <= 1'b1;
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
        end else if (bvalid_q && s_axi_bready) begin
            w_got_q  <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    // write response, unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // one read at a time; data is registered the cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
            rd_addr_q <= 8'h00;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {24'h000000, rd_byte};
            rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rd_addr_q <= 8'(s_axi_araddr);
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // control registers; the strap is caught while reset is held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl0_q.chan <= CHS_RST;
            ctl0_q.on   <= 1'b0;
            ctl1_q.nref <= 1'b0;
            ctl1_q.pref <= 1'b0;
            ctl1_q.pcfg <= strap_s2_q ? PCFG_ALL_ANALOG
                                      : PCFG_PB_DIGITAL;
        end else begin
            if (wr_ctl0) begin
                ctl0_q.chan <= wdata_q[CTL0_CHS_LSB +: 4];
                ctl0_q.on   <= new_on;
            end
            if (wr_ctl1) begin
                ctl1_q.nref <= wdata_q[CTL1_NREF_BIT];
                ctl1_q.pref <= wdata_q[CTL1_PREF_BIT];
                ctl1_q.pcfg <= wdata_q[CTL1_PCFG_LSB +: 4];
            end
        end
    end

    // result and done flag; a new completion beats a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_q    <= '0;
            done_flag_q <= 1'b0;
            done_mask_q <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            if (sar_done) begin
                result_q <= sar_result;
            end
            done_flag_q <= sar_done | (done_flag_q & ~clr_done);
            if (wr_imask) begin
                done_mask_q <= wdata_q[IRQ_DONE_BIT];
            end
            irq_q <= done_flag_q & done_mask_q;
        end
    end

    // pin-side selects held in flops so outputs never glitch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_valid_q <= 1'b0;
            sample_q     <= 1'b0;
            amask_q      <= '0;
        end else begin
            chan_valid_q <= chan_ok;
            sample_q     <= sar_sampling;
            amask_q      <= amask_d;
        end
    end

    acrc_sar #(
        .WIDTH (RES_W),
        .DIV   (DIV)
    ) u_sar (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start    (start_p),
        .abort    (abort_p),
        .comp     (comp_s2_q),
        .busy     (sar_busy),
        .done     (sar_done),
        .sampling (sar_sampling),
        .trial    (sar_trial),
        .result   (sar_result)
    );

    assign s_axi_awready             = awready_q;
    assign s_axi_wready              = wready_q;
    assign s_axi_bvalid              = bvalid_q;
    assign s_axi_bresp               = bresp_q;
    assign s_axi_arready             = arready_q;
    assign s_axi_rvalid              = rvalid_q;
    assign s_axi_rdata               = rdata_q;
    assign s_axi_rresp               = rresp_q;
    assign irq                       = irq_q;
    assign converter_on              = ctl0_q.on;
    assign analog_channel_select     = ctl0_q.chan;
    assign channel_valid             = chan_valid_q;
    assign negative_reference_select = ctl1_q.nref;
    assign positive_reference_select = ctl1_q.pref;
    assign analog_pin_mask           = amask_q;
    assign sample_hold               = sample_q;
    assign dac_code                  = sar_trial;

    // checks on the converter sequencing and register views
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_finish;
        sar_done ##1 (!sar_busy && done_flag_q);
    endsequence
    property p_done_result;
        sar_done |=> (result_q == $past(sar_result));
    endproperty
    a_done_result: assert property (p_done_result)
        else $error("result not loaded at completion");
    property p_done_status;
        sar_done |-> s_finish;
    endproperty
    a_done_status: assert property (p_done_status)
        else $error("status or flag wrong after completion");
    property p_abort_keeps;
        abort_p |=> (!sar_busy && $stable(result_q) && !sar_done) [*2];
    endproperty
    a_abort_keeps: assert property (p_abort_keeps)
        else $error("abort changed the result");
    property p_start;
        start_p |=> sar_busy ##1 sar_sampling;
    endproperty
    a_start: assert property (p_start)
        else $error("enabled start did not begin a conversion");
    property p_no_start_off;
        (wr_ctl0 && !ctl0_q.on && !sar_busy) |=> !sar_busy;
    endproperty
    a_no_start_off: assert property (p_no_start_off)
        else $error("conversion started while off");
    property p_rsvd_zero;
        (rvalid_q && (rd_addr_q == OFF_CTL0 || rd_addr_q == OFF_CTL1))
            |-> (s_axi_rdata[7:6] == 2'h0);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("unused control bits read nonzero");
    property p_float_chan;
        (ctl0_q.chan > CHS_LAST) |=> !channel_valid;
    endproperty
    a_float_chan: assert property (p_float_chan)
        else $error("unimplemented code routed an input");
    property p_all_digital;
        (ctl1_q.pcfg == 4'hF) [*2] |-> (analog_pin_mask == '0);
    endproperty
    a_all_digital: assert property (p_all_digital)
        else $error("code 15 left an analog input");
    property p_strap;
        $rose(aresetn) |-> (ctl1_q.pcfg == ($past(strap_s2_q)
            ? PCFG_ALL_ANALOG : PCFG_PB_DIGITAL));
    endproperty
    a_strap: assert property (p_strap)
        else $error("port field reset value wrong");
    property p_irq;
        (done_flag_q && done_mask_q) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked flag did not raise irq");
endmodule // acrc_top

// *** verif/acrc_analog_model.sv ***
// analog input model answering the converter's comparator
`timescale 1ns/1ps
module acrc_analog_model
    import acrc_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic [3:0]       analog_channel_select,
    input  wire logic             channel_valid,
    input  wire logic [RES_W-1:0] dac_code,
    output logic                  comparator_in
);
    logic             noise_q = 1'b0;
    logic [RES_W-1:0] level;
    // each input sits at a level that carries its channel number
    assign level = {analog_channel_select, 8'h5A};
    // a floating input flips every cycle, never a steady answer
    always_ff @(posedge aclk) begin
        noise_q <= ~noise_q;
    end
    // comparator high while the input lies above the trial code
    assign comparator_in = channel_valid ? (level > dac_code) : noise_q;
endmodule // acrc_analog_model

// *** verif/acrc_top_bench.sv ***
// self-checking bench of the converter control block
`timescale 1ns/1ps
module acrc_top_bench;
    import acrc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic portb_analog_default = 1'b1;
    logic comparator_in, irq, converter_on, channel_valid, sample_hold;
    logic negative_reference_select, positive_reference_select;
    logic [3:0] analog_channel_select;
    logic [N_IN-1:0] analog_pin_mask;
    logic [RES_W-1:0] dac_code;
    int errors = 0;
    int samples_checked = 0;
    // analog inputs left per port code, counted from input 0 upward
    int cnt [16] = '{13, 13, 13, 12, 11, 10, 9, 8, 7, 7, 6, 5, 3, 2, 1, 0};

    logic            chan_ok_small;
    logic [N_IN-1:0] pin_mask_small;

    // steps under 3 cycles would judge each trial on a stale comparator answer
    acrc_top #(.LARGE_PKG(1'b1), .DIV(BIT_DIV)) i_acrc_top (.*);
    // small-package twin on the same bus; only its pin views are checked
    acrc_top #(.LARGE_PKG(1'b0), .DIV(BIT_DIV)) i_acrc_top_small (.*,
        .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(),
        .s_axi_rresp(), .s_axi_rvalid(), .irq(), .converter_on(),
        .analog_channel_select(), .channel_valid(chan_ok_small),
        .negative_reference_select(), .positive_reference_select(),
        .analog_pin_mask(pin_mask_small), .sample_hold(), .dac_code());
    acrc_analog_model i_acrc_analog_model (.*);

    // 20 MHz clock
    initial begin
        forever #25 aclk = ~aclk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // a bounded wait that ran out ends the run
    task automatic tmo(input int n);
        if (n >= 100) begin
            errors++;
            $display("[FAIL] wait expected answer seen none");
            wrap_up();
        end
    endtask

    // each channel is released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask

    task automatic rc(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
        rdr(a, rd, rs);
        check(what, rd, exp);
    endtask

    // poll the status bit; polling avoids guessing the conversion length
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            rdr(OFF_CTL0, rd, rs);
            n++;
        end while (rd[1] !== 1'b0 && n < 100);
        tmo(n);
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rc("ctl0 reset", OFF_CTL0, 32'h0);
        rc("ctl1 reset", OFF_CTL1, 32'h0);
        check("mask reset", 32'(analog_pin_mask), 32'h1FFF);
        $display("test reset done");
        wr(OFF_CTL1, 8'hFF, rs);
        rc("ctl1 top bits", OFF_CTL1, 32'h3F);
        check("refs on", 32'({negative_reference_select,
                positive_reference_select}), 32'h3);
        for (int c = 0; c < 16; c++) begin
            wr(OFF_CTL1, 8'(c), rs);
            @(negedge aclk);
            check("pin mask", 32'(analog_pin_mask),
                  (32'h1 << cnt[c]) - 32'h1);
            check("small mask", 32'(pin_mask_small),
                  ((32'h1 << cnt[c]) - 32'h1) & 32'h1F1F);
        end
        check("refs off", 32'({negative_reference_select,
                positive_reference_select}), 32'h0);
        $display("test port config done");
        for (int c = 0; c < 16; c++) begin
            wr(OFF_CTL0, 8'((c << 2) | 1), rs);
            @(negedge aclk);
            check("chan sel", 32'(analog_channel_select), 32'(c));
            check("chan ok", 32'(channel_valid), 32'(c < 13));
            check("small chan", 32'(chan_ok_small),
                  32'(c < 5 || (c > 7 && c < 13)));
        end
        $display("test channels done");
        wr(OFF_CTL0, 8'h0C, rs);
        wr(OFF_CTL0, 8'h0E, rs);
        rc("go while off", OFF_CTL0, 32'h0C);
        check("on pin off", 32'(converter_on), 32'h0);
        wr(OFF_IMASK, 8'h01, rs);
        wr(OFF_CTL0, 8'h0D, rs);
        check("on pin", 32'(converter_on), 32'h1);
        wr(OFF_CTL0, 8'h0F, rs);
        @(negedge aclk);
        check("sample pin", 32'(sample_hold), 32'h1);
        rc("busy", OFF_CTL0, 32'h0F);
        wait_idle();
        rc("res high", OFF_RESH, 32'h3);
        rc("res low", OFF_RESL, 32'h59);
        rc("done flag", OFF_ISTAT, 32'h1);
        check("irq", 32'(irq), 32'h1);
        wr(OFF_IMASK, 8'h00, rs);
        @(negedge aclk);
        check("irq masked", 32'(irq), 32'h0);
        wr(OFF_ISTAT, 8'h01, rs);
        rc("flag cleared", OFF_ISTAT, 32'h0);
        $display("test conversion done");
        wr(OFF_CTL0, 8'h21, rs);
        wr(OFF_CTL0, 8'h23, rs);
        wr(OFF_CTL0, 8'h21, rs);
        repeat (60) @(posedge aclk);
        rc("abort idle", OFF_CTL0, 32'h21);
        rc("abort keeps", OFF_RESL, 32'h59);
        rc("abort no flag", OFF_ISTAT, 32'h0);
        $display("test abort done");
        wr(8'h18, 8'hFF, rs);
        check("unmapped wr", 32'(rs), 32'(RESP_SLVERR));
        rdr(8'h18, rd, rs);
        check("unmapped rd", 32'(rs), 32'(RESP_SLVERR));
        check("unmapped data", rd, 32'h0);
        $display("test unmapped done");
        // second reset with the strap low: port field must load 7
        portb_analog_default <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rc("ctl1 strap low", OFF_CTL1, 32'h07);
        check("mask strap low", 32'(analog_pin_mask), 32'hFF);
        check("small strap low", 32'(pin_mask_small), 32'h1F);
        rc("ctl0 reset again", OFF_CTL0, 32'h0);
        $display("test strap done");
        wrap_up();
    end
endmodule // acrc_top_bench
